// file: hw/rsc_consts.vh
/*
 * Constants of the reset source and start-up controller: register offsets,
 * bit positions, reset values, vectors and timing counts.
 * Assumes it is included by bare name from the design file.
 */
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// Register offsets (word index on the plain register port)
`define RSC_ADDR_CAUSE 2'h0
`define RSC_ADDR_STAT 2'h1
`define RSC_ADDR_BCTL 2'h2

// Reset cause register bit positions
`define RSC_CAUSE_OVF 7
`define RSC_CAUSE_UNF 6
`define RSC_CAUSE_WDT 4
`define RSC_CAUSE_PIN 3
`define RSC_CAUSE_RI 2
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_BOR 0

// Status register bit positions
`define RSC_STAT_TO 4
`define RSC_STAT_PD 3

// Brownout control register bit positions
`define RSC_BCTL_SWEN 7
`define RSC_BCTL_RDY 0

// Brownout enable configuration field codes
`define RSC_BROWNOUT_ENABLE_CFG_OFF 2'h0
`define RSC_BROWNOUT_ENABLE_CFG_SW 2'h1
`define RSC_BROWNOUT_ENABLE_CFG_NOSLP 2'h2
`define RSC_BROWNOUT_ENABLE_CFG_ON 2'h3

// Reset values
`define RSC_SWEN_RST 1'h1
`define RSC_BOR_FLAG_POR 1'h1

// Program counter vectors
`define RSC_RESET_VEC 15'h0000
`define RSC_INT_VEC 15'h0004

// Timing
`define RSC_CLK_KHZ 50000
`define RSC_POWER_UP_TIMER_MS 64
`define RSC_START_DLY 10
`define RSC_PIN_FILT 4

`endif

// file: hw/rsc_reset_ctrl.v
/*
 * Reset source combiner, power-up timer, start-up sequencer and reset
 * cause flags, with an 8-bit plain register port.
 * Assumes detector, pin and oscillator-ready inputs are asynchronous, and
 * core event inputs are one-cycle pulses on ref_clk_i.
 */
// Overview of operation
// - Brownout config 00 keeps brownout off; software enable bit then has no effect.
// - Generic brownout reset is low-power brownout OR main brownout.
// - Both brownout detectors update one shared brownout cause flag.
// - A configuration bit enables the low-power detector; erased means disabled.
// - Pin reset enabled when low-voltage programming set, else by pin-reset enable.
// - Enabled reset pin held low keeps the device in reset.
// - Reset pin input is filtered so short glitches are ignored.
// - Device never drives the reset pin low for any reset.
// - Disabled pin reset makes the pin a general input with software pull-up.
// - Watchdog timeout resets, clears its flag and marks the timeout status flag.
// - Software reset instruction resets and clears its active-low flag.
// - Stack overflow/underflow reset only when enabled; matching flag records it.
// - Leaving programming mode behaves exactly like a device reset.
// - Enabled power-up timer holds reset 64 ms after power-on or brownout.
// - Power-up timer counts only after power-on and brownout are released.
// - Execution waits for power-up timer, reset pin and oscillator start-up.
// - Timers run independently of pin; execution starts ten cycles after release.
// - Power-on reset loads its flag pattern and restart address zero.
// - Brownout reset loads its flag pattern, keeps watchdog and power-on flags.
// - Watchdog wake resumes at PC+1; watchdog reset restarts at zero.
// - Pin reset clears its flag; during sleep also sets timeout, clears powerdown.
// - Interrupt wake with global enable runs PC+1, then vectors to 0004h.
// - Stack resets set their flag, leave others, restart at zero.
// - Brownout config 01 lets the software enable bit switch brownout.
`timescale 1ns/100ps
`include "rsc_consts.vh"

module rsc_reset_ctrl #(
    parameter CNT_W = 22,
    parameter [CNT_W-1:0] POWER_UP_TIMER_CYCLES = `RSC_POWER_UP_TIMER_MS * `RSC_CLK_KHZ,
    parameter [3:0] START_CYCLES = `RSC_START_DLY,
    parameter [3:0] FILT_CYCLES = `RSC_PIN_FILT,
    parameter PC_W = 15
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Register port
    input wire [1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // Configuration bits
    input wire [1:0] brownout_enable_cfg_i,
    input wire low_power_brownout_cfg_i,
    input wire pin_reset_enable_cfg_i,
    input wire low_voltage_prog_cfg_i,
    input wire stack_reset_enable_cfg_i,
    input wire power_up_timer_enable_n_i,
    // Analog monitors and oscillator (asynchronous)
    input wire por_i,
    input wire brownout_det_i,
    input wire low_power_brownout_det_i,
    input wire brownout_ready_i,
    input wire osc_startup_done_i,
    input wire osc_startup_needed_i,
    // Reset pin
    input wire master_clear_pin_i,
    output wire master_clear_pin_o,
    output wire master_clear_pin_oe_o,
    output wire pin_pullup_en_o,
    output wire pin_gpio_o,
    input wire pin_pullup_sw_i,
    // Core events
    input wire watchdog_timeout_i,
    input wire reset_instr_i,
    input wire stack_overflow_i,
    input wire stack_underflow_i,
    input wire prog_mode_exit_i,
    input wire sleep_i,
    input wire int_wake_i,
    input wire global_int_enable_i,
    input wire [PC_W-1:0] pc_i,
    // Reset and restart outputs
    output wire brownout_active_o,
    output wire brownout_reset_o,
    output wire device_reset_o,
    output wire run_o,
    output reg pc_load_o,
    output reg [PC_W-1:0] pc_value_o,
    output reg int_vector_o
);

    localparam NSYNC = 6;

    // Synchroniser stages for the asynchronous inputs
    reg [NSYNC-1:0] sync_a_q;
    reg [NSYNC-1:0] sync_b_q;

    // Reset pin glitch filter
    reg filt_q;
    reg [3:0] filt_cnt_q;
    reg pin_low_q;

    // Power-up timer
    reg power_up_timer_run_q;
    reg [CNT_W-1:0] power_up_timer_cnt_q;

    // Start-up sequencer and restart vector
    reg running_q;
    reg [3:0] dly_cnt_q;
    reg vec_pend_q;

    // Software brownout enable, stored in every mode
    reg sw_en_q;

    // Cause flags, active-high stack flags and active-low others
    reg ovf_q;
    reg unf_q;
    reg wdt_n_q;
    reg pin_n_q;
    reg ri_n_q;
    reg por_n_q;
    reg bor_n_q;

    // Status flags, active low, and the active-high brownout enable
    reg to_n_q;
    reg pd_n_q;
    reg bor_en;

    // Synchronised views; only the second stage is ever read
    wire por_s = sync_b_q[0];
    wire bor_s = sync_b_q[1];
    wire low_power_brownout_s = sync_b_q[2];
    wire pin_s = sync_b_q[3];
    wire rdy_s = sync_b_q[4];
    wire osc_s = sync_b_q[5];

    // Two-stage synchroniser for every asynchronous input
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sync_a_q <= 6'h08;
            sync_b_q <= 6'h08;
        end else begin
            sync_a_q <= {osc_startup_done_i, brownout_ready_i, master_clear_pin_i,
                         low_power_brownout_det_i, brownout_det_i, por_i};
            sync_b_q <= sync_a_q;
        end
    end

    // Brownout detection enable by configuration mode
    always @* begin
        case (brownout_enable_cfg_i)
            `RSC_BROWNOUT_ENABLE_CFG_ON: bor_en = 1'b1;
            `RSC_BROWNOUT_ENABLE_CFG_NOSLP: bor_en = ~sleep_i;
            `RSC_BROWNOUT_ENABLE_CFG_SW: bor_en = sw_en_q;
            default: bor_en = 1'b0;
        endcase
    end

    wire low_power_brownout_rst = low_power_brownout_s & low_power_brownout_cfg_i;
    wire bor_gen = (bor_s & bor_en) | low_power_brownout_rst;
    wire power_rst = por_s | bor_gen;

    assign brownout_active_o = bor_en;
    assign brownout_reset_o = bor_gen;

    // Pin reset function and glitch filter
    wire pin_en = low_voltage_prog_cfg_i | pin_reset_enable_cfg_i;

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            filt_q <= 1'b1;
            filt_cnt_q <= 4'h0;
        end else if (pin_s != filt_q) begin
            if (filt_cnt_q == FILT_CYCLES - 4'h1) begin
                filt_q <= pin_s;
                filt_cnt_q <= 4'h0;
            end else begin
                filt_cnt_q <= filt_cnt_q + 4'h1;
            end
        end else begin
            filt_cnt_q <= 4'h0;
        end
    end

    wire pin_low = pin_en & ~filt_q;
    wire pin_fall = pin_low & ~pin_low_q;

    // Pin is never driven; pull-up follows software when pin reset is off
    assign master_clear_pin_o = 1'b0;
    assign master_clear_pin_oe_o = 1'b0;
    assign pin_pullup_en_o = pin_en ? 1'b1 : pin_pullup_sw_i;
    assign pin_gpio_o = pin_s;

    // Power-up timer, independent of the pin
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            power_up_timer_run_q <= 1'b0;
            power_up_timer_cnt_q <= {CNT_W{1'b0}};
        end else if (power_rst) begin
            power_up_timer_run_q <= ~power_up_timer_enable_n_i;
            power_up_timer_cnt_q <= {CNT_W{1'b0}};
        end else if (power_up_timer_run_q) begin
            if (power_up_timer_cnt_q == POWER_UP_TIMER_CYCLES - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                power_up_timer_run_q <= 1'b0;
            end
            power_up_timer_cnt_q <= power_up_timer_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Event resets
    wire wdt_rst = watchdog_timeout_i & ~sleep_i;
    wire wdt_wake = watchdog_timeout_i & sleep_i & running_q;
    wire irq_wake = int_wake_i & sleep_i & running_q;
    wire stk_ovf = stack_overflow_i & stack_reset_enable_cfg_i;
    wire stk_unf = stack_underflow_i & stack_reset_enable_cfg_i;
    wire evt_rst = wdt_rst | reset_instr_i | stk_ovf | stk_unf | prog_mode_exit_i;
    wire osc_ok = ~osc_startup_needed_i | osc_s;
    wire hold = power_rst | power_up_timer_run_q | pin_low | ~osc_ok | evt_rst;

    // Start-up delay and restart vector
    // Any hold restarts the delay, so even a one-cycle event reset gives
    // the core the full start delay before the restart address is loaded
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_low_q <= 1'b0;
            running_q <= 1'b0;
            dly_cnt_q <= 4'h0;
            vec_pend_q <= 1'b0;
            pc_load_o <= 1'b0;
            pc_value_o <= `RSC_RESET_VEC;
            int_vector_o <= 1'b0;
        end else begin
            pin_low_q <= pin_low;
            pc_load_o <= 1'b0;
            int_vector_o <= 1'b0;
            vec_pend_q <= 1'b0;
            if (hold) begin
                running_q <= 1'b0;
                dly_cnt_q <= 4'h0;
            end else if (!running_q) begin
                if (dly_cnt_q == START_CYCLES - 4'h1) begin
                    running_q <= 1'b1;
                    pc_load_o <= 1'b1;
                    pc_value_o <= `RSC_RESET_VEC;
                end
                dly_cnt_q <= dly_cnt_q + 4'h1;
            end else if (wdt_wake | irq_wake) begin
                pc_load_o <= 1'b1;
                pc_value_o <= pc_i + {{(PC_W-1){1'b0}}, 1'b1};
                vec_pend_q <= irq_wake & global_int_enable_i;
            end else if (vec_pend_q) begin
                int_vector_o <= 1'b1;
                pc_load_o <= 1'b1;
                pc_value_o <= `RSC_INT_VEC;
            end
        end
    end

    assign device_reset_o = ~running_q;
    assign run_o = running_q;

    // Cause and status flags; hardware updates win over software writes
    wire wr_cause = reg_wr_i & (reg_addr_i == `RSC_ADDR_CAUSE);
    wire wr_stat = reg_wr_i & (reg_addr_i == `RSC_ADDR_STAT);
    wire wr_bctl = reg_wr_i & (reg_addr_i == `RSC_ADDR_BCTL);

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sw_en_q <= `RSC_SWEN_RST;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            wdt_n_q <= 1'b1;
            pin_n_q <= 1'b1;
            ri_n_q <= 1'b1;
            por_n_q <= 1'b0;
            bor_n_q <= `RSC_BOR_FLAG_POR;
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
        end else begin
            if (wr_bctl) begin
                sw_en_q <= reg_wdata_i[`RSC_BCTL_SWEN];
            end
            if (wr_cause) begin
                ovf_q <= reg_wdata_i[`RSC_CAUSE_OVF];
                unf_q <= reg_wdata_i[`RSC_CAUSE_UNF];
                wdt_n_q <= reg_wdata_i[`RSC_CAUSE_WDT];
                pin_n_q <= reg_wdata_i[`RSC_CAUSE_PIN];
                ri_n_q <= reg_wdata_i[`RSC_CAUSE_RI];
                por_n_q <= reg_wdata_i[`RSC_CAUSE_POR];
                bor_n_q <= reg_wdata_i[`RSC_CAUSE_BOR];
            end
            if (wr_stat) begin
                to_n_q <= reg_wdata_i[`RSC_STAT_TO];
                pd_n_q <= reg_wdata_i[`RSC_STAT_PD];
            end

            // Power-on outranks brownout, and both outrank event updates
            if (por_s) begin
                ovf_q <= 1'b0;
                unf_q <= 1'b0;
                wdt_n_q <= 1'b1;
                pin_n_q <= 1'b1;
                ri_n_q <= 1'b1;
                por_n_q <= 1'b0;
                to_n_q <= 1'b1;
                pd_n_q <= 1'b1;
            end else if (bor_gen) begin
                ovf_q <= 1'b0;
                unf_q <= 1'b0;
                pin_n_q <= 1'b1;
                ri_n_q <= 1'b1;
                bor_n_q <= 1'b0;
                to_n_q <= 1'b1;
                pd_n_q <= 1'b1;
            end else begin
                if (wdt_rst) begin
                    wdt_n_q <= 1'b0;
                    to_n_q <= 1'b0;
                end
                if (wdt_wake) begin
                    to_n_q <= 1'b0;
                    pd_n_q <= 1'b0;
                end
                if (irq_wake) begin
                    to_n_q <= 1'b1;
                    pd_n_q <= 1'b0;
                end
                if (pin_fall) begin
                    pin_n_q <= 1'b0;
                    if (sleep_i) begin
                        to_n_q <= 1'b1;
                        pd_n_q <= 1'b0;
                    end
                end
                if (reset_instr_i) begin
                    ri_n_q <= 1'b0;
                end
                if (stk_ovf) begin
                    ovf_q <= 1'b1;
                end
                if (stk_unf) begin
                    unf_q <= 1'b1;
                end
            end
        end
    end

    // Read data, one cycle after the read strobe
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `RSC_ADDR_CAUSE:
                    reg_rdata_o <= {ovf_q, unf_q, 1'b0, wdt_n_q, pin_n_q,
                                    ri_n_q, por_n_q, bor_n_q};
                `RSC_ADDR_STAT:
                    reg_rdata_o <= {3'h0, to_n_q, pd_n_q, 3'h0};
                `RSC_ADDR_BCTL:
                    reg_rdata_o <= {sw_en_q, 6'h00, rdy_s};
                default:
                    reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// file: tb/rsc_reset_ctrl_properties.sv
/* Port checker for the reset source controller.
   Assumes a bind into rsc_reset_ctrl; one clock, synchronous active-low reset. */
`timescale 1ns/100ps
module rsc_properties #(
    parameter PC_W = 15
) (
    // Clock, reset and configuration
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [1:0] brownout_enable_cfg_i,
    input wire pin_reset_enable_cfg_i,
    input wire low_voltage_prog_cfg_i,
    // Reset pin
    input wire master_clear_pin_i,
    input wire master_clear_pin_o,
    input wire master_clear_pin_oe_o,
    input wire pin_pullup_en_o,
    input wire pin_pullup_sw_i,
    // Core side
    input wire watchdog_timeout_i,
    input wire reset_instr_i,
    input wire sleep_i,
    input wire int_wake_i,
    input wire [PC_W-1:0] pc_i,
    input wire brownout_active_o,
    input wire run_o,
    input wire pc_load_o,
    input wire [PC_W-1:0] pc_value_o,
    input wire int_vector_o
);
    wire pin_en = pin_reset_enable_cfg_i || low_voltage_prog_cfg_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_pin_undriven: assert property (!master_clear_pin_oe_o && !master_clear_pin_o)
        else $error("reset pin driven");
    a_brownout_enable_cfg_off: assert property (brownout_enable_cfg_i == 2'h0 |-> !brownout_active_o)
        else $error("brownout on in off mode");
    a_pullup_sel: assert property (pin_pullup_en_o == (pin_en || pin_pullup_sw_i))
        else $error("pull-up select wrong");
    a_instr_reset: assert property (run_o && reset_instr_i |=> !run_o)
        else $error("reset instruction ignored");
    a_wdt_reset: assert property (run_o && watchdog_timeout_i && !sleep_i |=> !run_o)
        else $error("watchdog timeout ignored");
    a_wake_pc: assert property (run_o && sleep_i && (watchdog_timeout_i || int_wake_i)
        |=> pc_load_o && pc_value_o == $past(pc_i) + 1'h1)
        else $error("wake address wrong");
    a_int_vector: assert property (int_vector_o |-> pc_load_o && $past(pc_load_o))
        else $error("vector without preceding load");
    a_vector_addr: assert property (int_vector_o |-> pc_value_o == 15'h0004)
        else $error("vector address wrong");
    a_start_load: assert property ($rose(run_o) |-> pc_load_o && !$past(run_o, 8))
        else $error("start without load or delay");
    a_pin_hold: assert property ((pin_en && !master_clear_pin_i)[*8] |-> ##2 !run_o)
        else $error("held pin did not reset");
endmodule

// file: tb/rsc_far_side.sv
/* Far-side model: supply monitors, oscillator start-up and reset pin driver.
   Assumes cmd_i bits: 0 power-on, 1 brownout, 2 low-power brownout, 3 pin low. */
`timescale 1ns/100ps
module rsc_far_side #(
    parameter int OSC_DLY = 80
) (
    // Clock and bench commands
    input wire ref_clk_i,
    input wire [3:0] cmd_i,
    // Monitor levels
    output wire por_o,
    output wire bor_o,
    output wire lp_bor_o,
    output wire bor_ready_o,
    output wire osc_done_o,
    // Reset pin level
    output wire pin_o
);
    int osc_cnt = 0;
    assign por_o = cmd_i[0];
    assign bor_o = cmd_i[1];
    assign lp_bor_o = cmd_i[2];
    assign bor_ready_o = !cmd_i[0];
    // Weak pull-up lifts the pin whenever the outside driver lets go
    assign pin_o = !cmd_i[3];
    // Start-up timer restarts with every power-on
    always @(posedge ref_clk_i) begin
        osc_cnt <= cmd_i[0] ? 0 : osc_cnt + (osc_cnt < OSC_DLY);
    end
    assign osc_done_o = (osc_cnt == OSC_DLY);
endmodule

// file: tb/testbench.sv
/* Self-checking bench for the reset source controller.
   Assumes the far-side model and the bound port checker. */
`timescale 1ns/100ps
module testbench;
    localparam int PW = 50;
    localparam int OSC = 80;
    localparam int SD = 10;
    logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, sleep_i = 0;
    logic low_power_brownout_cfg_i = 0, pin_reset_enable_cfg_i = 1, low_voltage_prog_cfg_i = 0;
    logic stack_reset_enable_cfg_i = 0, pin_pullup_sw_i = 0, global_int_enable_i = 0;
    logic power_up_timer_enable_n_i = 0, osc_startup_needed_i = 1;
    logic [1:0] reg_addr_i = 2'h0, brownout_enable_cfg_i = 2'h3;
    logic [7:0] reg_wdata_i = 8'h00, mc = 8'h1D, ms = 8'h18;
    logic [5:0] ev = 6'h00;
    logic [3:0] cmd = 4'h1;
    logic [14:0] pc_i = 15'h0000;
    wire por_i, brownout_det_i, low_power_brownout_det_i, brownout_ready_i, osc_startup_done_i;
    wire master_clear_pin_i, master_clear_pin_o, master_clear_pin_oe_o, pin_pullup_en_o, pin_gpio_o;
    wire brownout_active_o, brownout_reset_o, device_reset_o, run_o, pc_load_o, int_vector_o;
    wire [7:0] reg_rdata_o;
    wire [14:0] pc_value_o;
    int err_total = 0, checks_done = 0, n;

    rsc_reset_ctrl #(.POWER_UP_TIMER_CYCLES(PW)) dut (.*, .watchdog_timeout_i(ev[0]),
        .reset_instr_i(ev[1]), .stack_overflow_i(ev[2]), .stack_underflow_i(ev[3]),
        .int_wake_i(ev[4]), .prog_mode_exit_i(ev[5]));
    rsc_far_side #(.OSC_DLY(OSC)) far (.ref_clk_i, .cmd_i(cmd), .por_o(por_i),
        .bor_o(brownout_det_i), .lp_bor_o(low_power_brownout_det_i),
        .bor_ready_o(brownout_ready_i), .osc_done_o(osc_startup_done_i),
        .pin_o(master_clear_pin_i));

    always #10 ref_clk_i = ~ref_clk_i;

    task automatic chk(string s, logic [15:0] g, logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(logic [1:0] a, logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'h0;
        #1 chk("rdata", reg_rdata_o, e);
    endtask
    task automatic pulse(int i);
        @(posedge ref_clk_i);
        ev[i] <= 1'h1;
        @(posedge ref_clk_i);
        ev <= 6'h00;
        #1;
    endtask
    task automatic wait_run(output int c);
        for (c = 0; run_o !== 1'h1 && c < 500; c++) @(posedge ref_clk_i) #1;
    endtask
    task automatic ev_reset(int i);
        pulse(i);
        chk("dev_reset", device_reset_o, 1'h1);
        @(posedge ref_clk_i);
        wait_run(n);
        chk("restart", n >= SD - 3 && n <= SD + 3, 1'h1);
    endtask
    task automatic done(string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_total++;
        stop_test;
    end

    initial begin
        n = $urandom(34469);
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        rd(2'h0, 8'h1D);
        rd(2'h1, 8'h18);
        cmd <= 4'h0;
        wait_run(n);
        chk("por_delay", n >= OSC && n <= OSC + 20, 1'h1);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        rd(2'h2, 8'h81);
        wr(2'h0, 8'hC0);
        wr(2'h1, 8'h00);
        chk("sw_set", run_o, 1'h1);
        rd(2'h0, 8'hC0);
        wr(2'h0, 8'h1F);
        wr(2'h1, 8'h18);
        mc = 8'h1F;
        done("power_on");
        ev_reset(1);
        mc[2] = 1'h0;
        rd(2'h0, mc);
        ev_reset(0);
        mc[4] = 1'h0;
        ms[4] = 1'h0;
        rd(2'h0, mc);
        rd(2'h1, ms);
        ev_reset(5);
        rd(2'h0, mc);
        pulse(2);
        repeat (4) @(posedge ref_clk_i);
        chk("stack_off", run_o, 1'h1);
        stack_reset_enable_cfg_i <= 1'h1;
        ev_reset(2);
        ev_reset(3);
        mc[7:6] = 2'h3;
        rd(2'h0, mc);
        done("events");
        for (int i = 0; i < 2; i++) begin
            pc_i <= 15'($urandom % 32'h7FFF);
            sleep_i <= 1'h1;
            global_int_enable_i <= i[0];
            pulse(i ? 4 : 0);
            chk("wake_pc", {pc_load_o, pc_value_o}, {1'h1, pc_i + 15'h0001});
            @(posedge ref_clk_i) sleep_i <= 1'h0;
            #1 chk("vector", {int_vector_o, pc_value_o}, i ? 16'h8004 : {1'h0, pc_i + 15'h0001});
            ms[4] = i[0];
            ms[3] = 1'h0;
            rd(2'h1, ms);
        end
        done("wake");
        for (int i = 0; i < 8; i++) begin
            brownout_enable_cfg_i <= i[2:1];
            wr(2'h2, {i[0], 7'h00});
            #1 chk("bor_on", brownout_active_o, i >= 3);
            rd(2'h2, {i[0], 6'h00, 1'h1});
        end
        done("bor_modes");
        cmd <= 4'h8;
        @(posedge ref_clk_i) cmd <= 4'h0;
        repeat (12) @(posedge ref_clk_i);
        chk("glitch", run_o, 1'h1);
        sleep_i <= 1'h1;
        cmd <= 4'h8;
        repeat (30) @(posedge ref_clk_i);
        chk("pin_gpio", pin_gpio_o, 1'h0);
        sleep_i <= 1'h0;
        cmd <= 4'h0;
        mc[3] = 1'h0;
        ms[4:3] = 2'h2;
        wait_run(n);
        chk("pin_delay", n >= SD && n <= SD + 8, 1'h1);
        rd(2'h0, mc);
        rd(2'h1, ms);
        for (int i = 0; i < 8; i++) begin
            {pin_reset_enable_cfg_i, low_voltage_prog_cfg_i, pin_pullup_sw_i} <= i[2:0];
            @(posedge ref_clk_i) #1 chk("pullup", pin_pullup_en_o, |i[2:0]);
        end
        done("pin");
        for (int i = 0; i < 3; i++) begin
            low_power_brownout_cfg_i <= (i == 2);
            cmd <= (i == 1) ? 4'h2 : 4'h4;
            repeat (5) @(posedge ref_clk_i);
            chk("bor_out", brownout_reset_o, i > 0);
            cmd <= 4'h0;
            if (i > 0) begin
                mc = mc & 8'h12 | 8'h0C;
                ms = 8'h18;
            end
            wait_run(n);
            chk("bor_delay", i > 0 ? n >= PW && n <= PW + 20 : n == 0, 1'h1);
            rd(2'h0, mc);
            rd(2'h1, ms);
        end
        done("brownout");
        stop_test;
    end
endmodule

bind rsc_reset_ctrl rsc_properties #(.PC_W(PC_W)) u_props (.*);
